// ---- logic/sxc_pkg.sv ----
`default_nettype none
package sxc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL1 = 8'h01;
  localparam logic [7:0] IDX_CTRL3 = 8'h03;
  localparam logic [7:0] IDX_OWN_ID = 8'h04;
  localparam logic [7:0] IDX_XFER = 8'h05;
  localparam logic [7:0] IDX_RESPONSE_ID_REG = 8'h10;
  localparam logic [7:0] IDX_STATUS = 8'h11;
  localparam logic [7:0] IDX_ROLE = 8'h12;
  localparam logic [7:0] A_CTRL1 = {IDX_CTRL1[5:0], 2'b00};
  localparam logic [7:0] A_CTRL3 = {IDX_CTRL3[5:0], 2'b00};
  localparam logic [7:0] A_OWN_ID = {IDX_OWN_ID[5:0], 2'b00};
  localparam logic [7:0] A_XFER = {IDX_XFER[5:0], 2'b00};
  localparam logic [7:0] A_RESPONSE_ID_REG = {IDX_RESPONSE_ID_REG[5:0], 2'b00};
  localparam logic [7:0] A_STATUS = {IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] A_ROLE = {IDX_ROLE[5:0], 2'b00};
  // Writable bits of each register except STATUS
  localparam logic [7:0] CTRL1_WMASK = 8'h80;
  localparam logic [7:0] CTRL3_WMASK = 8'h70;
  localparam logic [7:0] OWN_ID_WMASK = 8'h67;
  localparam logic [7:0] XFER_WMASK = 8'hEF;
  localparam logic [7:0] RESPONSE_ID_REG_WMASK = 8'hFF;
  localparam logic [7:0] ROLE_WMASK = 8'h01;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL3_RST = 8'h00;
  localparam logic [7:0] OWN_ID_RST = 8'h00;
  localparam logic [7:0] XFER_RST = 8'h00;
  localparam logic [7:0] RESPONSE_ID_REG_RST = 8'h00;
  localparam logic [7:0] ROLE_RST = 8'h00;
  // Field positions
  localparam int EXT_SETUP_BIT = 7;
  localparam int SCF_LSB = 4;
  localparam int RRE_BIT = 6;
  localparam int SRE_BIT = 5;
  localparam int ID_LSB = 0;
  localparam int TP_LSB = 5;
  localparam int MO_LSB = 0;
  localparam int ROLE_TGT_BIT = 0;
  // Timing figures
  localparam logic [3:0] PERIOD_BASE = 4'h4;
  localparam logic [3:0] OFFSET_MAX = 4'h8;
  // Divider limits in half steps of the input clock
  localparam logic [3:0] LIM_DIV1 = 4'h2;
  localparam logic [3:0] LIM_DIV1P5 = 4'h3;
  localparam logic [3:0] LIM_DIV2 = 4'h4;
  localparam logic [3:0] LIM_DIV3 = 4'h6;
  localparam logic [3:0] LIM_DIV4 = 4'h8;
  localparam logic [3:0] LIM_NONE = 4'h0;
  // Bus phase codes on MSG, C/D, I/O
  localparam logic [2:0] PH_DATA_OUT = 3'h0;
  localparam logic [2:0] PH_DATA_IN = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [2:0] period_code;
    logic ext_setup;
    logic [2:0] scf;
    logic [3:0] max_offset;
  } sxc_sync_cfg_type;
endpackage
`default_nettype wire

// ---- logic/sxc_clk_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module sxc_clk_div import sxc_pkg::*; #(
  parameter int ACC_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] code,
  output logic en
);
  if (ACC_W < 4) begin
    $error("sxc_clk_div: ACC_W below 4");
  end
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] lim;
  logic [ACC_W-1:0] sum;
  always_comb begin
    unique case (code)
      3'h0: lim = ACC_W'(LIM_DIV3);
      3'h1: lim = ACC_W'(LIM_DIV1);
      3'h2: lim = ACC_W'(LIM_DIV1P5);
      3'h3: lim = ACC_W'(LIM_DIV2);
      3'h4: lim = ACC_W'(LIM_DIV3);
      3'h5: lim = ACC_W'(LIM_DIV4);
      default: lim = ACC_W'(LIM_NONE);
    endcase
  end
  assign sum = acc_q + ACC_W'(2);
  // Two half steps per cycle; fractional ratios fall out
  always_ff @(posedge aclk) begin
    if (!aresetn || lim == '0) begin
      acc_q <= '0;
      en <= 1'b0;
    end else if (sum >= lim) begin
      acc_q <= sum - lim;
      en <= 1'b1;
    end else begin
      acc_q <= sum;
      en <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- logic/sxc_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module sxc_config import sxc_pkg::*; #(
  parameter int ID_COUNT = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ti_load,
  input wire logic [7:0] ti_data,
  input wire logic [7:0] bus_data_pin,
  input wire logic [2:0] bus_phase_pin,
  input wire logic arb_active,
  input wire logic sel_seen,
  input wire logic resel_seen,
  input wire logic sending,
  input wire logic xfer_active,
  output logic [7:0] arb_id_drive,
  output logic arb_won,
  output logic sel_respond,
  output logic resel_respond,
  output logic role_target,
  output logic sync_tick,
  output logic [3:0] sync_period_clocks,
  output logic [3:0] max_sync_offset,
  output logic sync_mode
);
  // Priority decoding assumes eight IDs
  if (ID_COUNT != 8) begin
    $error("sxc_config: ID_COUNT must be 8");
  end

  // Registers
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl3_q;
  logic [7:0] own_id_q;
  logic [7:0] xfer_q;
  logic [7:0] response_id_reg_q;
  logic [7:0] role_q;
  sxc_sync_cfg_type cfg;

  // Bus write channel state
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic wr_go;
  logic wr_hit;
  logic wr_lane;

  // Pin synchronisers
  logic [7:0] data_s1_q;
  logic [7:0] data_s2_q;
  logic [2:0] phase_s1_q;
  logic [2:0] phase_s2_q;

  // Timing
  logic core_en;
  logic [3:0] period_d;
  logic [3:0] period_q;
  logic [3:0] cnt_q;
  logic [3:0] offset_d;
  logic data_phase;
  logic [7:0] own_onehot;
  logic [7:0] higher_mask;
  logic [7:0] rd_d;
  logic rd_hit;
  logic resp_hit;
  logic period_last;

  assign cfg = '{
    period_code: xfer_q[TP_LSB +: 3],
    ext_setup: ctrl1_q[EXT_SETUP_BIT],
    scf: ctrl3_q[SCF_LSB +: 3],
    max_offset: xfer_q[MO_LSB +: 4]
  };

  // Write address and data taken in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_lane = wr_go && wlane_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (awaddr_q)
      A_CTRL1, A_CTRL3, A_OWN_ID, A_XFER, A_RESPONSE_ID_REG, A_STATUS, A_ROLE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; reserved bits masked off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= CTRL1_RST;
      ctrl3_q <= CTRL3_RST;
      own_id_q <= OWN_ID_RST;
      response_id_reg_q <= RESPONSE_ID_REG_RST;
      role_q <= ROLE_RST;
    end else if (wr_lane) begin
      unique case (awaddr_q)
        A_CTRL1: ctrl1_q <= wdata_q & CTRL1_WMASK;
        A_CTRL3: ctrl3_q <= wdata_q & CTRL3_WMASK;
        A_OWN_ID: own_id_q <= wdata_q & OWN_ID_WMASK;
        A_RESPONSE_ID_REG: response_id_reg_q <= wdata_q & RESPONSE_ID_REG_WMASK;
        A_ROLE: role_q <= wdata_q & ROLE_WMASK;
        default: ;
      endcase
    end
  end

  // Transfer register: table-indirect load wins over a bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_q <= XFER_RST;
    end else if (ti_load) begin
      xfer_q <= ti_data;
    end else if (wr_lane && awaddr_q == A_XFER) begin
      xfer_q <= wdata_q & XFER_WMASK;
    end
  end

  // Reads
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      A_CTRL1: rd_d = ctrl1_q;
      A_CTRL3: rd_d = ctrl3_q;
      A_OWN_ID: rd_d = own_id_q;
      A_XFER: rd_d = xfer_q;
      A_RESPONSE_ID_REG: rd_d = response_id_reg_q;
      A_STATUS: rd_d = {max_sync_offset, sync_period_clocks};
      A_ROLE: rd_d = {5'h00, arb_won, sync_mode, role_q[ROLE_TGT_BIT]};
      default: begin
        rd_d = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_d};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Two flip-flops on the bus pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_s1_q <= 8'h00;
      data_s2_q <= 8'h00;
      phase_s1_q <= 3'h0;
      phase_s2_q <= 3'h0;
    end else begin
      data_s1_q <= bus_data_pin;
      data_s2_q <= data_s1_q;
      phase_s1_q <= bus_phase_pin;
      phase_s2_q <= phase_s1_q;
    end
  end

  // Own ID onto its data line during arbitration
  always_comb begin
    own_onehot = 8'h00;
    own_onehot[own_id_q[ID_LSB +: 3]] = 1'b1;
    higher_mask = ~((own_onehot << 1) - 8'h01);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arb_id_drive <= 8'h00;
      arb_won <= 1'b0;
    end else begin
      arb_id_drive <= arb_active ? own_onehot : 8'h00;
      arb_won <= arb_active && ((data_s2_q & higher_mask) == 8'h00);
    end
  end

  // Answers to selection and reselection; role left alone
  assign resp_hit = |(data_s2_q & response_id_reg_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_respond <= 1'b0;
      resel_respond <= 1'b0;
    end else begin
      sel_respond <= own_id_q[SRE_BIT] && sel_seen && resp_hit;
      resel_respond <= own_id_q[RRE_BIT] && resel_seen && resp_hit;
    end
  end

  assign role_target = role_q[ROLE_TGT_BIT];

  // Synchronous core clock enable
  sxc_clk_div #(
    .ACC_W(4)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .code(cfg.scf),
    .en(core_en)
  );

  // Period in core clocks, setup clock only while sending
  always_comb begin
    period_d = {1'b0, cfg.period_code} + PERIOD_BASE;
    if (sending && cfg.ext_setup) begin
      period_d = period_d + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= PERIOD_BASE;
    end else begin
      period_q <= period_d;
    end
  end

  assign sync_period_clocks = period_q;

  assign period_last = cnt_q >= period_q - 4'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
      sync_tick <= 1'b0;
    end else if (!xfer_active) begin
      cnt_q <= 4'h0;
      sync_tick <= 1'b0;
    end else if (core_en && period_last) begin
      cnt_q <= 4'h0;
      sync_tick <= 1'b1;
    end else begin
      cnt_q <= core_en ? cnt_q + 4'h1 : cnt_q;
      sync_tick <= 1'b0;
    end
  end

  // Offset only in data phases; reserved codes fall back to asynchronous
  assign data_phase = phase_s2_q == PH_DATA_OUT || phase_s2_q == PH_DATA_IN;

  always_comb begin
    if (data_phase && cfg.max_offset <= OFFSET_MAX) begin
      offset_d = cfg.max_offset;
    end else begin
      offset_d = 4'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      max_sync_offset <= 4'h0;
      sync_mode <= 1'b0;
    end else begin
      max_sync_offset <= offset_d;
      sync_mode <= offset_d != 4'h0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/sxc_config_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module sxc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic arb_active,
  input wire logic [7:0] arb_id_drive,
  input wire logic arb_won,
  input wire logic sel_seen,
  input wire logic sel_respond,
  input wire logic resel_seen,
  input wire logic resel_respond,
  input wire logic role_target,
  input wire logic [2:0] bus_phase_pin,
  input wire logic [3:0] max_sync_offset,
  input wire logic [3:0] sync_period_clocks,
  input wire logic xfer_active,
  input wire logic sync_tick
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_arb_idle: assert property (!arb_active |=> arb_id_drive == 8'h00)
    else $error("id drive while idle");
  a_arb_onehot: assert property (arb_active |=> $onehot(arb_id_drive))
    else $error("id drive not one line");
  a_won_cause: assert property (arb_won |-> $past(arb_active))
    else $error("won without arbitrating");
  a_sel_cause: assert property (sel_respond |-> $past(sel_seen))
    else $error("selection answer without selection");
  a_resel_cause: assert property (resel_respond |-> $past(resel_seen))
    else $error("reselection answer without reselection");
  a_role_soft: assert property ($changed(role_target) |-> $rose(s_axi_bvalid))
    else $error("role changed without write");
  a_period_span: assert property (sync_period_clocks inside {[4'h4:4'hC]})
    else $error("period out of span");
  a_offset_cap: assert property (max_sync_offset <= 4'h8)
    else $error("offset above eight");
  a_async_phase: assert property ((bus_phase_pin[2:1] != 2'b00) [*4] |-> max_sync_offset == 4'h0)
    else $error("offset outside data phase");
  a_tick_idle: assert property (!xfer_active [*2] |-> !sync_tick)
    else $error("tick while idle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_data: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
endmodule
bind sxc_config sxc_chk u_chk (.*);
`default_nettype wire

// ---- tb/sxc_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sxc_bus_model (
  input wire logic aclk,
  input wire logic [7:0] ids,
  input wire logic [2:0] ph,
  output logic [7:0] bus_data_pin,
  output logic [2:0] bus_phase_pin
);
  // Other devices assert their ID lines; released lines sit deasserted
  always @(posedge aclk) begin
    bus_data_pin <= ids;
    bus_phase_pin <= ph;
  end
endmodule
`default_nettype wire

// ---- tb/tb_scsi_id_and_sync_xfer_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_scsi_id_and_sync_xfer_config;
  import sxc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ti_data, ids, bus_data_pin, arb_id_drive;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, sync_period_clocks, max_sync_offset;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] ph, bus_phase_pin;
  logic ti_load, arb_active, sel_seen, resel_seen, sending, xfer_active, arb_won;
  logic sel_respond, resel_respond, role_target, sync_tick, sync_mode;
  int err_count, total_checks;
  sxc_config uut (.*);
  sxc_bus_model u_bus (.aclk, .ids, .ph, .bus_data_pin, .bus_phase_pin);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY,
          input logic late = 1'b0);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= {1'b1, !late};
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    if (late) begin
      repeat (2) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(negedge aclk);
    end
    chk(s_axi_rdata, {24'h0, e});
    chk(s_axi_rresp, er);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task t_regs;
    rd(A_XFER, 8'h00);
    rd(A_OWN_ID, 8'h00);
    chk(sync_period_clocks, 4'h4);
    wr(A_OWN_ID, 8'hFF, RESP_OKAY);
    rd(A_OWN_ID, 8'h67);
    s_axi_wstrb <= 4'hE;
    wr(A_OWN_ID, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(A_OWN_ID, 8'h67, RESP_OKAY, 1'b1);
    wr(A_XFER, 8'hFF, RESP_OKAY);
    rd(A_XFER, 8'hEF);
    wr(8'hFC, 8'h55, RESP_SLVERR);
    rd(8'hFC, 8'h00, RESP_SLVERR);
  endtask
  task t_period;
    for (int c = 0; c < 8; c++) begin
      for (int x = 0; x < 4; x++) begin
        wr(A_CTRL1, {x[0], 7'h0}, RESP_OKAY);
        wr(A_XFER, {c[2:0], 5'h0}, RESP_OKAY);
        sending <= x[1];
        settle(3);
        chk(sync_period_clocks, c + 4 + (x[0] & x[1]));
      end
    end
    wr(A_CTRL1, 8'h00, RESP_OKAY);
  endtask
  task t_offset;
    for (int o = 0; o < 16; o++) begin
      wr(A_XFER, {4'h0, o[3:0]}, RESP_OKAY);
      ph <= o[0] ? PH_DATA_IN : PH_DATA_OUT;
      settle(4);
      chk(max_sync_offset, (o <= 8) ? o : 0);
      chk(sync_mode, o >= 1 && o <= 8);
      @(posedge aclk);
      ph <= 3'h3;
      settle(4);
      chk(max_sync_offset, 4'h0);
    end
  endtask
  task t_ti;
    @(posedge aclk);
    ti_data <= 8'hFF;
    ti_load <= 1'b1;
    @(posedge aclk);
    ti_load <= 1'b0;
    rd(A_XFER, 8'hFF);
    rd(A_STATUS, 8'h0B);
  endtask
  task t_arb;
    wr(A_OWN_ID, 8'h03, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      @(posedge aclk);
      ids <= 8'h01 << k;
      arb_active <= 1'b1;
      settle(5);
      chk(arb_won, k <= 3);
      chk(arb_id_drive, 8'h08);
      if (k == 0) rd(A_ROLE, 8'h04);
    end
    @(posedge aclk);
    arb_active <= 1'b0;
  endtask
  task t_sel;
    wr(A_RESPONSE_ID_REG, 8'h20, RESP_OKAY);
    for (int m = 0; m < 16; m++) begin
      wr(A_OWN_ID, {1'b0, m[1:0], 5'h0}, RESP_OKAY);
      @(posedge aclk);
      ids <= m[3] ? 8'h41 : 8'h21;
      sel_seen <= !m[2];
      resel_seen <= m[2];
      settle(4);
      chk(sel_respond, m[0] & !m[2] & !m[3]);
      chk(resel_respond, m[1] & m[2] & !m[3]);
      chk(role_target, 1'b0);
      @(posedge aclk);
      {sel_seen, resel_seen, ids} <= 10'h0;
    end
    wr(A_ROLE, 8'h01, RESP_OKAY);
    chk(role_target, 1'b1);
    wr(A_ROLE, 8'h00, RESP_OKAY);
  endtask
  task t_div;
    int tk[8];
    int n;
    tk = '{8, 24, 16, 12, 8, 6, 0, 0};
    wr(A_XFER, 8'h00, RESP_OKAY);
    sending <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(A_CTRL3, {1'b0, c[2:0], 4'h0}, RESP_OKAY);
      xfer_active <= 1'b1;
      n = 0;
      repeat (96) begin
        @(negedge aclk);
        n += (sync_tick === 1'b1);
      end
      @(posedge aclk);
      xfer_active <= 1'b0;
      chk(n >= tk[c] - 1 && n <= tk[c] + 1, 1'b1);
    end
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, ti_data, ids, s_axi_wdata} = 64'h0;
    {ti_load, arb_active, sel_seen, resel_seen, sending, xfer_active} = 6'h0;
    s_axi_wstrb = 4'hF;
    ph = PH_DATA_OUT;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_period;
    t_offset;
    t_ti;
    t_arb;
    t_sel;
    t_div;
    give_verdict;
  end
  initial begin
    #2000000;
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
